// >>> fsw_status_wp.sv
// Status bytes, write latch and write protection of a serial flash.
// Assumes pins arrive from the host clock domain and are resynchronised.
`timescale 1ns/1ps
module fsw_status_wp (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire fsw_pkg::fsw_pins_type pins,
    output logic                     so,
    output logic                     so_oe,
    output logic                     hold_active,
    output logic                     busy,
    output logic                     in_dpd,
    output logic [1:0]               drive_strength,
    output logic [2:0]               secure_lock,
    output fsw_pkg::fsw_op_type      op
);
    import fsw_pkg::*;

    fsw_state_type r_reg;
    fsw_state_type r_next;
    logic          rise;
    logic          fall;
    logic          hold_now;
    logic          wp_low;
    logic          sw_ok;
    logic          sw_commit;
    logic          ce_commit;
    logic          resume_cmd;
    logic [7:0]    byt;
    logic [7:0]    st_low;
    logic [7:0]    st_mid;
    logic [7:0]    st_high;

    assign rise = r_reg.s2.sck & ~r_reg.sck_d;
    assign fall = ~r_reg.s2.sck & r_reg.sck_d;
    assign byt  = {r_reg.shift[6:0], r_reg.s2.si};
    // Pause and guard pins are data lanes while four-lane mode is on
    assign hold_now = ~r_reg.qe & ~r_reg.s2.hold_n;
    assign wp_low   = ~r_reg.qe & ~r_reg.s2.wp_n;
    assign sw_ok    = r_reg.write_latch_flag
                    && r_reg.lock != LOCK_POWER
                    && !(r_reg.lock == LOCK_HW && wp_low);

    assign st_low  = {r_reg.lock[0], r_reg.bp, r_reg.write_latch_flag, r_reg.write_in_flight_flag};
    assign st_mid  = {r_reg.ers_p, r_reg.cmp, r_reg.lb, r_reg.prg_p,
                      r_reg.qe, r_reg.lock[1]};
    assign st_high = {1'b0, r_reg.drv, 5'h00};

    always_comb begin
        r_next         = r_reg;
        sw_commit      = 1'b0;
        ce_commit      = 1'b0;
        resume_cmd     = 1'b0;
        r_next.s1      = pins;
        r_next.s2      = r_reg.s1;
        r_next.sck_d   = r_reg.s2.sck;
        r_next.op.prog_go  = 1'b0;
        r_next.op.erase_go = 1'b0;
        r_next.op.quad_go  = 1'b0;
        r_next.hold    = hold_now & r_reg.sel;
        if (r_reg.cnt != 10'h0) begin
            r_next.cnt = r_reg.cnt - 10'h1;
        end

        if (r_reg.s2.cs_n) begin
            r_next.sel    = 1'b0;
            r_next.bit_i  = 3'h0;
            r_next.nbytes = 3'h0;
            r_next.ph     = PH_OPCODE;
            r_next.so_oe  = 1'b0;
            // Commands take effect when the frame closes on whole bytes
            if (r_reg.sel && r_reg.bit_i == 3'h0 && r_reg.ph == PH_COLLECT)
            begin
                if (r_reg.opc != OPC_RST_EN) begin
                    r_next.rst_en = 1'b0;
                end
                if (r_reg.write_in_flight_flag) begin
                    if (r_reg.opc == OPC_SUSPEND && r_reg.nbytes == 3'h0)
                    begin
                        if (r_reg.kind == KIND_ERASE) begin
                            r_next.ers_p = 1'b1;
                            r_next.saved = r_reg.cnt;
                            r_next.cnt   = 10'h0;
                        end else if (r_reg.kind == KIND_PROG) begin
                            r_next.prg_p = 1'b1;
                            r_next.saved = r_reg.cnt;
                            r_next.cnt   = 10'h0;
                        end
                    end
                end else begin
                    unique case (r_reg.opc)
                        OPC_WR_EN: begin
                            if (r_reg.nbytes == 3'h0) begin
                                r_next.write_latch_flag = 1'b1;
                            end
                        end
                        OPC_WR_DIS: begin
                            r_next.write_latch_flag = 1'b0;
                        end
                        OPC_WR_LOW, OPC_WR_MID, OPC_WR_HIGH: begin
                            if (r_reg.nbytes == 3'h1 && sw_ok) begin
                                sw_commit    = 1'b1;
                                r_next.write_latch_flag   = 1'b0;
                                r_next.kind  = KIND_STATUS;
                                r_next.cnt   = CYC_STATUS;
                            end
                        end
                        OPC_PROG, OPC_QPROG: begin
                            if (r_reg.nbytes == 3'h4 && r_reg.write_latch_flag
                                && (r_reg.opc == OPC_PROG || r_reg.qe)) begin
                                r_next.write_latch_flag = 1'b0;
                                // Shielded pages are refused silently
                                if (!fsw_protected(r_reg.arg, r_reg.bp,
                                                   r_reg.cmp)) begin
                                    r_next.op.prog_go = 1'b1;
                                    r_next.op.chip    = 1'b0;
                                    r_next.op.addr    = r_reg.arg;
                                    r_next.kind       = KIND_PROG;
                                    r_next.cnt        = CYC_PROG;
                                end
                            end
                        end
                        OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K: begin
                            if (r_reg.nbytes == 3'h3 && r_reg.write_latch_flag) begin
                                r_next.write_latch_flag = 1'b0;
                                if (!fsw_protected(r_reg.arg, r_reg.bp,
                                                   r_reg.cmp)) begin
                                    r_next.op.erase_go = 1'b1;
                                    r_next.op.chip     = 1'b0;
                                    r_next.op.addr     = r_reg.arg;
                                    r_next.kind        = KIND_ERASE;
                                    r_next.cnt         = CYC_ERASE;
                                end
                            end
                        end
                        OPC_CHIP_A, OPC_CHIP_B: begin
                            if (r_reg.nbytes == 3'h0 && r_reg.write_latch_flag) begin
                                r_next.write_latch_flag = 1'b0;
                                if (fsw_chip_ok(r_reg.bp, r_reg.cmp)) begin
                                    ce_commit          = 1'b1;
                                    r_next.op.erase_go = 1'b1;
                                    r_next.op.chip     = 1'b1;
                                    r_next.op.addr     = 24'h0;
                                    r_next.kind        = KIND_ERASE;
                                    r_next.cnt         = CYC_ERASE;
                                end
                            end
                        end
                        OPC_RESUME: begin
                            resume_cmd = 1'b1;
                            if (r_reg.ers_p || r_reg.prg_p) begin
                                r_next.cnt = r_reg.saved;
                            end
                            r_next.ers_p = 1'b0;
                            r_next.prg_p = 1'b0;
                        end
                        OPC_DPD: begin
                            r_next.dpd = 1'b1;
                        end
                        OPC_DPD_REL: begin
                            r_next.dpd = 1'b0;
                        end
                        OPC_RST_EN: begin
                            r_next.rst_en = 1'b1;
                        end
                        OPC_RST: begin
                            if (r_reg.rst_en) begin
                                r_next.write_latch_flag = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end else if (!hold_now) begin
            r_next.sel   = 1'b1;
            r_next.so_oe = (r_reg.ph == PH_READ);
            if (rise) begin
                r_next.shift = byt;
                r_next.bit_i = r_reg.bit_i + 3'h1;
                if (r_reg.bit_i == 3'h7) begin
                    unique case (r_reg.ph)
                        PH_OPCODE: begin
                            r_next.opc = byt;
                            r_next.ph  = PH_COLLECT;
                            if (r_reg.dpd && byt != OPC_DPD_REL) begin
                                r_next.ph = PH_IGNORE;
                            end else if (byt == OPC_RD_LOW) begin
                                r_next.ph   = PH_READ;
                                r_next.obuf = st_low;
                            end else if (byt == OPC_RD_MID) begin
                                r_next.ph   = PH_READ;
                                r_next.obuf = st_mid;
                            end else if (byt == OPC_RD_HIGH) begin
                                r_next.ph   = PH_READ;
                                r_next.obuf = st_high;
                            end else if ((byt == OPC_QREAD_O
                                          || byt == OPC_QREAD_IO
                                          || byt == OPC_QREAD_W)
                                         && !r_reg.write_in_flight_flag) begin
                                r_next.ph         = PH_IGNORE;
                                r_next.op.quad_go = r_reg.qe;
                            end
                        end
                        PH_COLLECT: begin
                            if (r_reg.nbytes < 3'h3) begin
                                r_next.arg = {r_reg.arg[15:0], byt};
                            end
                            if (r_reg.nbytes != 3'h4) begin
                                r_next.nbytes = r_reg.nbytes + 3'h1;
                            end
                        end
                        PH_READ, PH_IGNORE: begin
                        end
                    endcase
                end
            end
            // Status byte repeats while the frame stays open
            if (fall && r_reg.ph == PH_READ) begin
                r_next.so   = r_reg.obuf[7];
                r_next.obuf = {r_reg.obuf[6:0], r_reg.obuf[7]};
            end
        end else begin
            r_next.so_oe = 1'b0;
        end

        // Only the addressed byte changes; reserved bits are dropped
        if (sw_commit) begin
            unique case (r_reg.opc)
                OPC_WR_LOW: begin
                    r_next.bp = r_reg.arg[POS_BP_LSB +: 5];
                    if ({r_reg.lock[1], r_reg.arg[POS_LOCK_LO]}
                        != LOCK_NONE) begin
                        r_next.lock[0] = r_reg.arg[POS_LOCK_LO];
                    end
                end
                OPC_WR_MID: begin
                    if ({r_reg.arg[POS_LOCK_HI], r_reg.lock[0]}
                        != LOCK_NONE) begin
                        r_next.lock[1] = r_reg.arg[POS_LOCK_HI];
                    end
                    r_next.qe  = r_reg.arg[POS_QE];
                    r_next.cmp = r_reg.arg[POS_CMP];
                    r_next.lb  = r_reg.lb
                               | r_reg.arg[POS_LB_LSB +: 3];
                end
                default: begin
                    r_next.drv = r_reg.arg[POS_DRV_LSB +: 2];
                end
            endcase
        end
        r_next.write_in_flight_flag = (r_next.cnt != 10'h0);
    end

    // Power cycle returns defaults, so a power lock-down releases here
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r_reg         <= '0;
            r_reg.s1.cs_n <= 1'b1;
            r_reg.s2.cs_n <= 1'b1;
            r_reg.qe      <= QE_RESET;
            r_reg.lock    <= LOCK_SOFT;
            r_reg.drv     <= DRV_RESET;
            r_reg.ph      <= PH_OPCODE;
            r_reg.kind    <= KIND_NONE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign so             = r_reg.so;
    assign so_oe          = r_reg.so_oe;
    assign hold_active    = r_reg.hold;
    assign busy           = r_reg.write_in_flight_flag;
    assign in_dpd         = r_reg.dpd;
    assign drive_strength = r_reg.drv;
    assign secure_lock    = r_reg.lb;
    assign op             = r_reg.op;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_status_write_busy: assert property
        (sw_commit |=> r_reg.write_in_flight_flag[*8])
        else $error("busy not held after status write");
    chk_write_needs_latch: assert property (sw_commit |-> r_reg.write_latch_flag)
        else $error("status write without write latch");
    chk_latch_cleared: assert property (sw_commit |=> !r_reg.write_latch_flag)
        else $error("write latch survives status write");
    chk_power_lock_holds: assert property
        (r_reg.lock == LOCK_POWER |-> !sw_commit)
        else $error("status written under power lock");
    chk_hw_lock_guard: assert property
        (r_reg.lock == LOCK_HW && wp_low |-> !sw_commit)
        else $error("status written while guard pin low");
    chk_lock_never_11: assert property (r_reg.lock != LOCK_NONE)
        else $error("prohibited lock select reached");
    chk_otp_sticky: assert property
        (1'b1 |=> (r_reg.lb & $past(r_reg.lb)) == $past(r_reg.lb))
        else $error("one-time lock bit cleared");
    chk_chip_erase_gate: assert property
        (ce_commit |=> r_reg.op.erase_go && r_reg.op.chip
            && fsw_chip_ok(r_reg.bp, r_reg.cmp))
        else $error("chip erase with wrong protect setting");
    chk_erase_outside: assert property
        (r_reg.op.erase_go && !r_reg.op.chip
            |-> !fsw_protected(r_reg.op.addr, r_reg.bp, r_reg.cmp))
        else $error("erase issued into shielded region");
    chk_dpd_no_write: assert property (r_reg.dpd |-> !sw_commit)
        else $error("status written in deep power-down");
    chk_resume_clears: assert property
        (resume_cmd |=> !r_reg.ers_p && !r_reg.prg_p)
        else $error("paused flags kept after resume");
    chk_pause_pin_quad: assert property (r_reg.qe |=> !r_reg.hold)
        else $error("pause honoured in four-lane mode");

endmodule

// >>> fsw_pkg.sv
// Constants, types and helpers for the flash status and write-protect block.
// Assumes a single 40 MHz system clock samples every serial pin.
// Functional notes
// - Opcodes 05h, 35h, 15h read the low, middle and high status bytes.
// - Opcodes 01h, 31h, 11h write only the addressed status byte.
// - Busy bit reads 1 during program, erase or status write.
// - Bit S1 mirrors the write latch; latch clear rejects writes.
// - Five protect-range bits select region shielded from program and erase.
// - Protect-range field not writable in power lock state, nor in hardware lock state while guard pin low.
// - Chip erase only with range bits 000 and invert 0, or 111 and 1.
// - Lock select 00 permits status writes whenever the latch is set.
// - Lock select 01 refuses status writes while write-guard pin low.
// - Lock select 10 refuses writes until power cycle; 11 is prohibited.
// - Bit S9 at 1 turns guard and pause pins into data lanes.
// - Suspend command sets erase or program paused flag.
// - Resume command and power cycle clear both paused flags.
// - One-time lock bits start 0, set by status write, never clear; here resetn clears them to 0.
// - Invert bit defaults 0 and combines with range to pick region.
// - Output-strength field picks 100, 75, 50 or 25 percent drive.
// - In deep power-down only the release command is honoured.
// - Write enable sets latch; disable, writes, erases, reset clear it.
// - Invert bit 1 shields the complement of the normal region.
// - Quad read and program run only with four-lane enable set.
// - Pause pin honoured only while four-lane enable is 0.
package fsw_pkg;

    localparam logic [7:0] OPC_RD_LOW    = 8'h05;
    localparam logic [7:0] OPC_RD_MID    = 8'h35;
    localparam logic [7:0] OPC_RD_HIGH   = 8'h15;
    localparam logic [7:0] OPC_WR_LOW    = 8'h01;
    localparam logic [7:0] OPC_WR_MID    = 8'h31;
    localparam logic [7:0] OPC_WR_HIGH   = 8'h11;
    localparam logic [7:0] OPC_WR_EN     = 8'h06;
    localparam logic [7:0] OPC_WR_DIS    = 8'h04;
    localparam logic [7:0] OPC_PROG      = 8'h02;
    localparam logic [7:0] OPC_QPROG     = 8'h32;
    localparam logic [7:0] OPC_ERASE_4K  = 8'h20;
    localparam logic [7:0] OPC_ERASE_32K = 8'h52;
    localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
    localparam logic [7:0] OPC_CHIP_A    = 8'hc7;
    localparam logic [7:0] OPC_CHIP_B    = 8'h60;
    localparam logic [7:0] OPC_SUSPEND   = 8'h75;
    localparam logic [7:0] OPC_RESUME    = 8'h7a;
    localparam logic [7:0] OPC_DPD       = 8'hb9;
    localparam logic [7:0] OPC_DPD_REL   = 8'hab;
    localparam logic [7:0] OPC_RST_EN    = 8'h66;
    localparam logic [7:0] OPC_RST       = 8'h99;
    localparam logic [7:0] OPC_QREAD_O   = 8'h6b;
    localparam logic [7:0] OPC_QREAD_IO  = 8'heb;
    localparam logic [7:0] OPC_QREAD_W   = 8'he7;

    // Status field positions within each byte
    localparam int POS_LOCK_LO = 7;
    localparam int POS_BP_LSB  = 2;
    localparam int POS_LOCK_HI = 0;
    localparam int POS_QE      = 1;
    localparam int POS_LB_LSB  = 3;
    localparam int POS_CMP     = 6;
    localparam int POS_DRV_LSB = 5;

    localparam logic [1:0] LOCK_SOFT  = 2'h0;
    localparam logic [1:0] LOCK_HW    = 2'h1;
    localparam logic [1:0] LOCK_POWER = 2'h2;
    localparam logic [1:0] LOCK_NONE  = 2'h3;
    localparam logic       QE_RESET   = 1'b1;
    localparam logic [1:0] DRV_RESET  = 2'h0;

    localparam logic [23:0] RANGE_UNIT_BLK = 24'h040000;
    localparam logic [23:0] RANGE_UNIT_SEC = 24'h001000;

    // Internal busy times, in ns, and their cycle counts at 40 MHz
    localparam int CLK_NS       = 25;
    localparam int T_STATUS_NS  = 1000;
    localparam int T_PROG_NS    = 2000;
    localparam int T_ERASE_NS   = 4000;
    localparam logic [9:0] CYC_STATUS =
        10'((T_STATUS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] CYC_PROG   =
        10'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] CYC_ERASE  =
        10'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {PH_OPCODE, PH_READ, PH_COLLECT, PH_IGNORE}
        fsw_phase_type;
    typedef enum logic [1:0] {KIND_NONE, KIND_STATUS, KIND_PROG, KIND_ERASE}
        fsw_kind_type;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic hold_n;
    } fsw_pins_type;

    typedef struct packed {
        logic        prog_go;
        logic        erase_go;
        logic        chip;
        logic        quad_go;
        logic [23:0] addr;
    } fsw_op_type;

    typedef struct packed {
        fsw_pins_type  s1;
        fsw_pins_type  s2;
        logic          sck_d;
        logic          sel;
        fsw_phase_type ph;
        logic [2:0]    bit_i;
        logic [7:0]    shift;
        logic [7:0]    opc;
        logic [2:0]    nbytes;
        logic [23:0]   arg;
        logic [7:0]    obuf;
        logic          so;
        logic          so_oe;
        logic          hold;
        logic          write_in_flight_flag;
        logic          write_latch_flag;
        logic          qe;
        logic          cmp;
        logic          ers_p;
        logic          prg_p;
        logic          dpd;
        logic          rst_en;
        logic [4:0]    bp;
        logic [1:0]    lock;
        logic [1:0]    drv;
        logic [2:0]    lb;
        fsw_kind_type  kind;
        logic [9:0]    cnt;
        logic [9:0]    saved;
        fsw_op_type    op;
    } fsw_state_type;

    // Address falls inside the shielded region
    function automatic logic fsw_protected(input logic [23:0] a,
                                           input logic [4:0]  bp,
                                           input logic        cmp);
        logic [2:0]  n;
        logic [2:0]  sh;
        logic [23:0] size;
        logic        hit;
        n    = bp[2:0];
        sh   = 3'h0;
        size = 24'h0;
        hit  = 1'b0;
        if (n == 3'h7) begin
            hit = 1'b1;
        end else if (n != 3'h0) begin
            if (!bp[4]) begin
                size = RANGE_UNIT_BLK << (n - 3'h1);
            end else begin
                sh   = (n >= 3'h4) ? 3'h3 : n - 3'h1;
                size = RANGE_UNIT_SEC << sh;
            end
            hit = bp[3] ? (a < size) : (a >= (24'h0 - size));
        end
        return hit ^ cmp;
    endfunction

    function automatic logic fsw_chip_ok(input logic [4:0] bp,
                                         input logic       cmp);
        return (bp[2:0] == 3'h0 && !cmp) || (bp[2:0] == 3'h7 && cmp);
    endfunction

endpackage

// >>> fsw_host.sv
// SPI host model that drives the status block's pins.
// Assumes mclk is the block clock; one sck bit lasts 8 mclk.
`timescale 1ns/1ps
module fsw_host (
    input  wire logic             mclk,
    input  wire logic             so,
    output fsw_pkg::fsw_pins_type pins
);
    import fsw_pkg::*;
    initial pins = 5'b10011;
    task automatic guard(input logic v);
        pins.wp_n = v;
    endtask
    // Opcode then bytes, MSB first; one byte read back if rd
    task automatic frame(input int n, input logic [31:0] tx,
                         input bit rd, output logic [7:0] rx);
        @(negedge mclk);
        pins.cs_n = 1'b0;
        for (int i = 0; i < 8 * (n + rd); i++) begin
            pins.si = (i < 8 * n) ? tx[31-i] : ~pins.si;
            repeat (4) @(negedge mclk);
            pins.sck = 1'b1;
            repeat (4) @(negedge mclk);
            rx = {rx[6:0], so};
            pins.sck = 1'b0;
        end
        repeat (4) @(negedge mclk);
        pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        repeat (6) @(negedge mclk);
    endtask
endmodule

// >>> flash_status_and_write_protect_tb.sv
// Self-checking bench for the flash status and write-protect block.
// Assumes the host model in fsw_host drives all serial pins.
`timescale 1ns/1ps
module flash_status_and_write_protect_tb;
    import fsw_pkg::*;
    typedef struct packed {logic [7:0] w, d, r, e;} fsw_row_type;
    logic         mclk = 1'b0;
    logic         resetn = 1'b0;
    fsw_pins_type pins;
    logic         so, so_oe, hold_active, busy, in_dpd;
    logic [1:0]   drv;
    logic [2:0]   lb;
    fsw_op_type   op;
    logic [7:0]   rx;
    int           n_errors = 0, n_tests = 0, n_ers = 0, cyc = 0, n_q = 0;
    fsw_row_type  rows [6] = '{'{8'h01, 8'h1c, 8'h05, 8'h1c},
        '{8'h31, 8'h42, 8'h35, 8'h42}, '{8'h11, 8'h60, 8'h15, 8'h60},
        '{8'h11, 8'hff, 8'h15, 8'h60}, '{8'h31, 8'h8e, 8'h35, 8'h0a},
        '{8'h31, 8'h02, 8'h35, 8'h0a}};
    fsw_host u_host (.mclk(mclk), .so(so), .pins(pins));
    fsw_status_wp dut (.mclk(mclk), .resetn(resetn), .pins(pins), .so(so),
        .so_oe(so_oe), .hold_active(hold_active), .busy(busy),
        .in_dpd(in_dpd), .drive_strength(drv), .secure_lock(lb), .op(op));
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (op.erase_go === 1'b1) n_ers++;
        if (op.quad_go === 1'b1) n_q++;
        if (cyc == 40000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic check(input string s, input logic [7:0] v, e);
        n_tests++;
        if (v !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", s, e, v);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        u_host.frame(1, {c, 24'h0}, 1'b0, rx);
    endtask
    task automatic rd(input logic [7:0] c, e);
        u_host.frame(1, {c, 24'h0}, 1'b1, rx);
        check("status", rx, e);
        check("enable", {7'h0, so_oe}, 8'h00);
    endtask
    // Latch, status write, then busy checked against b and 40-cycle busy let pass
    task automatic wr(input logic [7:0] c, d, input logic b);
        cmd(OPC_WR_EN);
        u_host.frame(2, {c, d, 16'h0}, 1'b0, rx);
        check("busy", {7'h0, busy}, {7'h0, b});
        repeat (60) @(negedge mclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        rd(OPC_RD_MID, 8'h02);
        foreach (rows[i]) begin
            wr(rows[i].w, rows[i].d, 1'b1);
            rd(rows[i].r, rows[i].e);
        end
        check("strength", {6'h0, drv}, 8'h03);
        check("locks", {5'h0, lb}, 8'h01);
        cmd(OPC_WR_EN);
        rd(OPC_RD_LOW, 8'h1e);
        cmd(OPC_WR_DIS);
        rd(OPC_RD_LOW, 8'h1c);
        u_host.frame(2, {OPC_WR_LOW, 24'h0}, 1'b0, rx);
        rd(OPC_RD_LOW, 8'h1c);
        cmd(OPC_WR_EN);
        cmd(OPC_CHIP_A);
        wr(OPC_WR_LOW, 8'h00, 1'b1);
        cmd(OPC_WR_EN);
        cmd(OPC_CHIP_A);
        repeat (200) @(negedge mclk);
        check("erases", n_ers[7:0], 8'h01);
        wr(OPC_WR_MID, 8'h00, 1'b1);
        cmd(OPC_QREAD_O);
        wr(OPC_WR_LOW, 8'h80, 1'b1);
        u_host.guard(1'b0);
        wr(OPC_WR_LOW, 8'h84, 1'b0);
        u_host.guard(1'b1);
        wr(OPC_WR_MID, 8'h01, 1'b1);
        rd(OPC_RD_MID, 8'h08);
        wr(OPC_WR_LOW, 8'h00, 1'b1);
        wr(OPC_WR_MID, 8'h09, 1'b1);
        wr(OPC_WR_LOW, 8'h04, 1'b0);
        resetn = 1'b0;
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        rd(OPC_RD_MID, 8'h02);
        cmd(OPC_DPD);
        check("sleep", {7'h0, in_dpd}, 8'h01);
        cmd(OPC_WR_EN);
        cmd(OPC_DPD_REL);
        rd(OPC_RD_LOW, 8'h00);
        wr(OPC_WR_LOW, 8'h18, 1'b1);
        cmd(OPC_WR_EN);
        u_host.frame(4, {OPC_ERASE_4K, 24'hf00000}, 1'b0, rx);
        cmd(OPC_WR_EN);
        u_host.frame(4, {OPC_ERASE_4K, 24'h001000}, 1'b0, rx);
        cmd(OPC_SUSPEND);
        check("suspended", {7'h0, busy}, 8'h00);
        rd(OPC_RD_MID, 8'h82);
        cmd(OPC_RESUME);
        check("resumed", {7'h0, busy}, 8'h01);
        rd(OPC_RD_MID, 8'h02);
        repeat (200) @(negedge mclk);
        check("erases", n_ers[7:0], 8'h02);
        check("address", op.addr[15:8], 8'h10);
        cmd(OPC_QREAD_O);
        check("quad", n_q[7:0], 8'h01);
        give_verdict();
    end
endmodule
